// ---- verilog/dmrf_pkg.sv ----
// constants for the main timing pll state and reference override block
package dmrf_pkg;
  // ==========================================
  // register map, byte addresses on the control bus
  localparam logic [3:0] REG_STATE_OFS = 4'h0;
  localparam logic [3:0] REG_SRC_OFS = 4'h4;
  localparam logic [3:0] REG_STATUS_OFS = 4'h8;
  // ==========================================
  // field widths and reset values
  localparam int STATE_W = 3;
  localparam int SRC_W = 4;
  localparam int N_REF = 4;
  localparam logic [2:0] STATE_RST = 3'h0;
  localparam logic [3:0] SRC_RST = 4'hF;
  // ==========================================
  // forced_state_code encodings
  localparam logic [2:0] STATE_AUTO = 3'h0;
  localparam logic [2:0] STATE_FREE_RUN = 3'h1;
  localparam logic [2:0] STATE_HOLDOVER = 3'h2;
  localparam logic [2:0] STATE_UNUSED = 3'h3;
  localparam logic [2:0] STATE_LOCKED = 3'h4;
  localparam logic [2:0] STATE_PRELOCK2 = 3'h5;
  localparam logic [2:0] STATE_PRELOCK = 3'h6;
  localparam logic [2:0] STATE_PHASE_LOST = 3'h7;
  // ==========================================
  // forced reference source encodings, entry i selects input i+1
  localparam logic [3:0] SRC_AUTO = 4'h0;
  localparam logic [3:0] SRC_AUTO_ALT = 4'hF;
  localparam logic [3:0] SRC_CODES [0:3] = '{4'h3, 4'h4, 4'h8, 4'h9};
  // ==========================================
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ---- verilog/dmrf_ovr_if.sv ----
// carrier between the override registers and the two code decoders
`timescale 1ns/1ps
`default_nettype none
interface dmrf_ovr_if;
  logic [2:0] state_code; // stored forced_state_code
  logic state_forced; // a state is being forced
  logic [3:0] src_code; // stored source override code
  logic src_forced; // a reference is being forced
  logic [3:0] src_sel; // one-hot forced input

  modport state_dec (input state_code, output state_forced);
  modport src_dec (input src_code, output src_forced, output src_sel);
  modport ctrl (output state_code, output src_code, input state_forced, input src_forced, input src_sel);
endinterface
`default_nettype wire

// ---- verilog/dmrf_state_dec.sv ----
// decoder for the forced operating state code
`timescale 1ns/1ps
`default_nettype none
module dmrf_state_dec (
  dmrf_ovr_if.state_dec bus // code in, force flag out
);
  // zero and the unused code leave the state machine in charge
  always_comb
  begin
    bus.state_forced = (bus.state_code != dmrf_pkg::STATE_AUTO) &&
                       (bus.state_code != dmrf_pkg::STATE_UNUSED);
  end
endmodule
`default_nettype wire

// ---- verilog/dmrf_src_dec.sv ----
// decoder for the forced reference source code
`timescale 1ns/1ps
`default_nettype none
module dmrf_src_dec (
  dmrf_ovr_if.src_dec bus // code in, selection out
);
  logic [3:0] hit;

  // one compare per input; unassigned codes match nothing
  for (genvar i = 0; i < dmrf_pkg::N_REF; i++)
  begin : g_ref
    assign hit[i] = (bus.src_code == dmrf_pkg::SRC_CODES[i]);
  end

  // no hit keeps automatic selection
  assign bus.src_sel = hit;
  assign bus.src_forced = |hit;
endmodule
`default_nettype wire

// ---- verilog/dmrf_top.sv ----
// axi4-lite override registers for main timing pll state and reference
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - zero and unused code 3 mean automatic, other codes force state
// - forced state suspends monitoring-driven transitions
// - codes 3,4,8,9 force inputs one to four
// - other source codes keep automatic selection
// - forced input bypasses monitoring, treated valid
// - forced input failure never disqualifies it
// - forced input gets top priority
// - source register resets to 0000 1111
module dmrf_top (
  input wire logic sys_clk, // 40 MHz system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [3:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [2:0] sm_state_code, // state from internal state machine
  input wire logic [3:0] mon_valid, // per-input monitor verdict
  input wire logic [3:0] mon_disq, // per-input disqualify request
  output logic [2:0] pll_state_code, // effective pll state
  output logic state_forced, // state override active
  output logic monitor_hold, // monitoring may not move state
  output logic ref_forced, // reference override active
  output logic [3:0] ref_force_sel, // one-hot forced input
  output logic [3:0] ref_valid, // per-input valid after bypass
  output logic [3:0] ref_disq, // per-input disqualify after bypass
  output logic [3:0] ref_top_prio // input raised to priority one
);
  // ==========================================
  // configuration registers
  logic [2:0] state_code_q, state_code_d;
  logic [3:0] src_code_q, src_code_d;

  dmrf_ovr_if ovr ();
  assign ovr.state_code = state_code_q;
  assign ovr.src_code = src_code_q;

  dmrf_state_dec u_state_dec (
    .bus (ovr)
  );

  dmrf_src_dec u_src_dec (
    .bus (ovr)
  );

  // ==========================================
  // write channel
  logic aw_hold_q, aw_hold_d;
  logic w_hold_q, w_hold_d;
  logic [3:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic do_write;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  // word indices of the three registers, declared before the decode uses them
  localparam logic [1:0] REG_IDX_STATE = dmrf_pkg::REG_STATE_OFS[3:2];
  localparam logic [1:0] REG_IDX_SRC = dmrf_pkg::REG_SRC_OFS[3:2];
  localparam logic [1:0] REG_IDX_STATUS = dmrf_pkg::REG_STATUS_OFS[3:2];

  // address and data taken in either order, response after both
  always_comb
  begin
    aw_hold_d = aw_hold_q | (s_axi_awvalid & awready_q);
    w_hold_d = w_hold_q | (s_axi_wvalid & wready_q);
    aw_addr_d = (s_axi_awvalid & awready_q) ? s_axi_awaddr : aw_addr_q;
    w_data_d = (s_axi_wvalid & wready_q) ? s_axi_wdata : w_data_q;
    w_strb_d = (s_axi_wvalid & wready_q) ? s_axi_wstrb : w_strb_q;
    wr_addr = aw_addr_d;
    wr_data = w_data_d;
    wr_strb = w_strb_d;
    do_write = aw_hold_d & w_hold_d;
    bvalid_d = bvalid_q & ~s_axi_bready;
    bresp_d = bresp_q;
    if (do_write)
    begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wr_addr[3:2] == REG_IDX_STATE || wr_addr[3:2] == REG_IDX_SRC ||
                 wr_addr[3:2] == REG_IDX_STATUS) ? dmrf_pkg::RESP_OKAY : dmrf_pkg::RESP_DECERR;
    end
    awready_d = ~aw_hold_d & ~bvalid_d;
    wready_d = ~w_hold_d & ~bvalid_d;
  end

  // register the write channel
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= dmrf_pkg::RESP_OKAY;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // ==========================================
  // override fields; only the low field bits are stored
  always_comb
  begin
    state_code_d = state_code_q;
    src_code_d = src_code_q;
    if (do_write && wr_strb[0])
    begin
      if (wr_addr[3:2] == REG_IDX_STATE)
        state_code_d = wr_data[2:0];
      if (wr_addr[3:2] == REG_IDX_SRC)
        src_code_d = wr_data[3:0];
    end
  end

  // reset leaves both selections automatic
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_code_q <= dmrf_pkg::STATE_RST;
      src_code_q <= dmrf_pkg::SRC_RST;
    end
    else
    begin
      state_code_q <= state_code_d;
      src_code_q <= src_code_d;
    end
  end

  // ==========================================
  // read channel
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  // one read at a time, data one cycle after the address is taken
  always_comb
  begin
    rvalid_d = rvalid_q & ~s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = dmrf_pkg::RESP_OKAY;
      case (s_axi_araddr[3:2])
        REG_IDX_STATE: rdata_d = {29'h0000_0000, state_code_q};
        REG_IDX_SRC: rdata_d = {28'h000_0000, src_code_q};
        REG_IDX_STATUS: rdata_d = {24'h00_0000, ref_force_sel, state_forced, pll_state_code};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = dmrf_pkg::RESP_DECERR;
        end
      endcase
    end
    arready_d = ~rvalid_d;
  end

  // register the read channel
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= dmrf_pkg::RESP_OKAY;
    end
    else
    begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ==========================================
  // override outputs toward the pll and selector
  logic [2:0] pll_state_d;
  logic [3:0] ref_valid_d, ref_disq_d;

  // forced state replaces the state machine; forced input is valid
  always_comb
  begin
    pll_state_d = ovr.state_forced ? state_code_q : sm_state_code;
    ref_valid_d = mon_valid | ovr.src_sel;
    ref_disq_d = mon_disq & ~ovr.src_sel;
  end

  // outputs straight from flip-flops
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pll_state_code <= dmrf_pkg::STATE_AUTO;
      state_forced <= 1'b0;
      monitor_hold <= 1'b0;
      ref_forced <= 1'b0;
      ref_force_sel <= 4'h0;
      ref_valid <= 4'h0;
      ref_disq <= 4'h0;
      ref_top_prio <= 4'h0;
    end
    else
    begin
      pll_state_code <= pll_state_d;
      state_forced <= ovr.state_forced;
      monitor_hold <= ovr.state_forced;
      ref_forced <= ovr.src_forced;
      ref_force_sel <= ovr.src_sel;
      ref_valid <= ref_valid_d;
      ref_disq <= ref_disq_d;
      ref_top_prio <= ovr.src_sel;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_state_write;
    do_write && wr_strb[0] && wr_addr[3:2] == REG_IDX_STATE;
  endsequence

  property p_state_auto;
    (state_code_q == dmrf_pkg::STATE_AUTO) |=> !state_forced && pll_state_code == $past(sm_state_code);
  endproperty
  a_state_auto: assert property (p_state_auto) else $error("auto code did not follow state machine");

  property p_state_force;
    s_state_write ##1 (state_code_q != dmrf_pkg::STATE_AUTO && state_code_q != dmrf_pkg::STATE_UNUSED)
      |=> state_forced && pll_state_code == $past(state_code_q);
  endproperty
  a_state_force: assert property (p_state_force) else $error("forced state not applied");

  property p_mon_hold;
    state_forced |-> monitor_hold && ($stable(pll_state_code) || $past(state_code_q, 2) != $past(state_code_q));
  endproperty
  a_mon_hold: assert property (p_mon_hold) else $error("state moved while forced");

  property p_src_force;
    (src_code_q == dmrf_pkg::SRC_CODES[3]) |=> ref_forced && ref_force_sel == 4'h8;
  endproperty
  a_src_force: assert property (p_src_force) else $error("input four not forced");

  property p_src_auto;
    (src_code_q == dmrf_pkg::SRC_AUTO_ALT || src_code_q == 4'h1) |=> !ref_forced && ref_force_sel == 4'h0;
  endproperty
  a_src_auto: assert property (p_src_auto) else $error("automatic source code forced an input");

  property p_bypass;
    ref_forced |-> (ref_valid & ref_force_sel) == ref_force_sel && (ref_disq & ref_force_sel) == 4'h0;
  endproperty
  a_bypass: assert property (p_bypass) else $error("forced input not bypassed");

  property p_top_prio;
    ref_forced |-> ref_top_prio == ref_force_sel && $onehot(ref_top_prio);
  endproperty
  a_top_prio: assert property (p_top_prio) else $error("forced input not top priority");

  property p_reset_vals;
    $fell(rst) |-> src_code_q == dmrf_pkg::SRC_RST && state_code_q == dmrf_pkg::STATE_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("override reset value wrong");

  property p_upper_zero;
    (s_axi_rvalid && s_axi_rresp == dmrf_pkg::RESP_OKAY) |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
endmodule
`default_nettype wire

// ---- verif/dmrf_testbench.sv ----
// self-checking bench for the pll state and reference override registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========================================
  // signals
  logic sys_clk;
  logic rst;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [2:0] sm, pll;
  logic [3:0] mval, mdq, rsel, rval, rdq, rprio;
  logic st_f, hold, rf;
  int failures;
  int n_tests;

  // ==========================================
  // design under test
  dmrf_top dut_u (
    .sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sm_state_code(sm), .mon_valid(mval), .mon_disq(mdq),
    .pll_state_code(pll), .state_forced(st_f), .monitor_hold(hold),
    .ref_forced(rf), .ref_force_sel(rsel), .ref_valid(rval), .ref_disq(rdq), .ref_top_prio(rprio)
  );

  // ==========================================
  // clock, 25 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ==========================================
  // report and compare helpers
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ==========================================
  // bus master tasks, release each channel when taken
  task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int i;
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 20 && !done; i++)
    begin
      @(posedge sys_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        done = 1'b1;
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
      end
    end
    if (!done)
    begin
      failures++;
      test_done();
    end
    @(posedge sys_clk);
  endtask

  task axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 20 && !done; i++)
    begin
      @(posedge sys_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        done = 1'b1;
        rready <= 1'b0;
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
      end
    end
    if (!done)
    begin
      failures++;
      test_done();
    end
    @(posedge sys_clk);
  endtask

  // ==========================================
  // scenarios
  task t_reset;
    axi_rd(4'h0, 32'h0000_0000, 2'h0);
    axi_rd(4'h4, 32'h0000_000F, 2'h0);
    chk(32'(st_f), 32'h0);
    chk(32'(rf), 32'h0);
    $display("test reset done");
  endtask

  // every state code, with upper bits set and the state machine input moving
  task t_state;
    int i;
    logic [2:0] c;
    logic f;
    for (i = 0; i < 8; i++)
    begin
      c = 3'(i);
      f = (c != 3'h0) && (c != 3'h3);
      sm <= 3'(7 - i);
      axi_wr(4'h0, 32'hFFFF_FFF8 | 32'(c), 4'hF, 2'h0);
      chk(32'(st_f), 32'(f));
      chk(32'(hold), 32'(f));
      chk(32'(pll), f ? 32'(c) : 32'(7 - i));
      axi_rd(4'h0, 32'(c), 2'h0);
      axi_rd(4'h8, {24'h0, 4'h0, f, (f ? c : 3'(7 - i))}, 2'h0);
    end
    axi_wr(4'h0, 32'h0, 4'hF, 2'h0);
    chk(32'(st_f), 32'h0);
    $display("test state done");
  endtask

  // every source code, monitors reporting a mix of valid and disqualify
  task t_src;
    int i;
    logic [3:0] c;
    logic [3:0] s;
    for (i = 0; i < 16; i++)
    begin
      c = 4'(i);
      mval <= 4'(i);
      mdq <= 4'(15 - i);
      s = (c == 4'h3) ? 4'h1 : (c == 4'h4) ? 4'h2 : (c == 4'h8) ? 4'h4 : (c == 4'h9) ? 4'h8 : 4'h0;
      axi_wr(4'h4, 32'hFFFF_FFF0 | 32'(c), 4'hF, 2'h0);
      chk(32'(rf), 32'(s != 4'h0));
      chk(32'(rsel), 32'(s));
      chk(32'(rval), 32'(mval | s));
      chk(32'(rdq), 32'(mdq & ~s));
      chk(32'(rprio), 32'(s));
      axi_rd(4'h4, 32'(c), 2'h0);
    end
    $display("test source done");
  endtask

  // unmapped word, masked byte lane and read-only status
  task t_bus;
    axi_wr(4'hC, 32'h0000_0001, 4'hF, 2'h3);
    axi_rd(4'hC, 32'h0000_0000, 2'h3);
    axi_wr(4'h4, 32'h0000_0003, 4'hE, 2'h0);
    axi_rd(4'h4, 32'h0000_000F, 2'h0);
    axi_wr(4'h8, 32'h0000_00FF, 4'hF, 2'h0);
    axi_rd(4'h8, {24'h0, 4'h0, 1'b0, sm}, 2'h0);
    chk(32'(rf), 32'h0);
    $display("test bus done");
  endtask

  // reset in mid-run with both overrides active
  task t_rerst;
    axi_wr(4'h0, 32'h0000_0004, 4'hF, 2'h0);
    axi_wr(4'h4, 32'h0000_0003, 4'hF, 2'h0);
    chk(32'(st_f), 32'h1);
    chk(32'(rf), 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk(32'(st_f), 32'h0);
    chk(32'(rf), 32'h0);
    axi_rd(4'h0, 32'h0000_0000, 2'h0);
    axi_rd(4'h4, 32'h0000_000F, 2'h0);
    $display("test reset again done");
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    failures = 0;
    n_tests = 0;
    rst = 1'b1;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    sm = 3'h2;
    mval = 4'h5;
    mdq = 4'hF;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_state();
    t_src();
    t_bus();
    t_rerst();
    test_done();
  end
endmodule
`default_nettype wire
